/* File: hdl/pldc_status_ctrl.sv */
// led, duplex, loopback and power-down control of the transceiver
`timescale 1ns/1ps
`include "pldc_params.svh"
module pldc_status_ctrl #(
   parameter int FAST_LOSS_CYC = `PLDC_FAST_LOSS_CYC, // fast loss count
   parameter int BLINK_BASE = `PLDC_BLINK_BASE // shortest half period
) (
   input wire logic sys_clk, // 100 MHz clock
   input wire logic sys_rst, // sync reset, high
   input wire pldc_pkg::pldc_line_type line, // phy core status
   input wire logic [1:0] modeSelWr, // mode field write value
   input wire logic modeSelWe, // mode field write strobe
   input wire pldc_pkg::pldc_led_ctrl_type ledCtrl, // led register
   input wire logic fastLossEn, // fast link loss enable
   input wire logic duplexWr, // duplex bit write value
   input wire logic duplexWe, // duplex bit write strobe
   input wire logic loopbackBit, // loopback control bit
   input wire logic powerDownBit, // power-down control bit
   input wire logic irqOutEn, // irq output enable bit
   input wire logic irqPending, // interrupt pending
   input wire logic [2:0] strapIn, // led pins read as straps
   input wire logic fiberStrap, // fiber mode strap
   input wire logic pdPinIn, // shared pin level in
   input wire logic [7:0] txData, // mii transmit data
   input wire logic txEn, // mii transmit enable
   input wire logic [7:0] rxLineData, // data from media
   input wire logic rxLineDv, // media receive valid
   output logic linkIndicator, // link led pin
   output logic speedIndicator, // speed led pin
   output logic activityIndicator, // activity led pin
   output logic [1:0] modeSel, // current mode field
   output logic duplexFull, // duplex bit
   output logic linkUp, // link status
   output logic crs, // mii carrier sense
   output logic colOut, // mii collision
   output logic [7:0] rxData, // mii receive data
   output logic rxDv, // mii receive valid
   output logic [7:0] mediaTxData, // data to media
   output logic mediaTxEn, // media transmit enable
   output logic loopbackSts, // status bit 3
   output logic powerDown, // device powered down
   output logic pdPinOut, // shared pin out level
   output logic pdPinOe // shared pin drive enable
);
   initial begin
      if (FAST_LOSS_CYC < 1 || BLINK_BASE < 1) begin
         $error("pldc_status_ctrl: counts must be at least one");
      end
   end

   typedef struct packed {
      logic [1:0] mode;
      logic duplex;
      logic [2:0] pol;
      logic strapDone;
      pldc_pkg::pldc_link_type link;
      logic [2:0] nlpCnt;
      logic [`PLDC_CNT_W-1:0] lossCnt;
      logic [`PLDC_CNT_W-1:0] blinkCnt;
      logic blinkPh;
      logic [2:0] led;
      logic crs;
      logic col;
      logic [7:0] rxd;
      logic rxdv;
      logic [7:0] txd;
      logic txen;
   } pldc_state_type;

   pldc_state_type st_r, st_nxt;
   logic [2:0] strapS;
   logic fiberS, pdPinS;
   logic activity, modeFunc2, modeFunc1, modeFunc0;
   logic [`PLDC_CNT_W-1:0] blinkTop;

   // pin inputs pass two flops
   pldc_sync #(.W(5)) u_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .din({strapIn, fiberStrap, pdPinIn}),
      .dout({strapS, fiberS, pdPinS})
   );

   // activity source
   assign activity = ledCtrl.rxOnly ? line.rxAct
                                    : (line.rxAct | line.txAct);
   // blink half period per rate field
   assign blinkTop = `PLDC_CNT_W'(BLINK_BASE << ledCtrl.blinkRate);

   // next state
   always_comb begin
      st_nxt = st_r;
      // strap capture after reset release
      if (!st_r.strapDone) begin
         st_nxt.strapDone = 1'b1;
         st_nxt.pol = strapS;
         st_nxt.mode[0] = strapS[0];
         st_nxt.mode[1] = 1'b0;
         if (fiberS) begin
            st_nxt.duplex = strapS[0];
         end else begin
            st_nxt.duplex = strapS[1];
         end
      end else begin
         if (modeSelWe) begin
            st_nxt.mode = modeSelWr;
         end
         if (duplexWe) begin
            st_nxt.duplex = duplexWr;
         end else if (line.parDet && !fiberS) begin
            st_nxt.duplex = 1'b0;
         end
      end
      // link state
      case (st_r.link)
         pldc_pkg::PLDC_NOLINK: begin
            st_nxt.nlpCnt = '0;
            if (line.speed100 ? line.sigDet : line.goodPkt) begin
               st_nxt.link = pldc_pkg::PLDC_UP;
            end else if (!line.speed100 && line.nlp) begin
               st_nxt.nlpCnt = 3'h1;
               st_nxt.link = pldc_pkg::PLDC_PULSES;
            end
         end
         pldc_pkg::PLDC_PULSES: begin
            if (line.speed100 || line.goodPkt) begin
               st_nxt.link = line.speed100 ? pldc_pkg::PLDC_NOLINK
                                           : pldc_pkg::PLDC_UP;
            end else if (line.nlp) begin
               st_nxt.nlpCnt = st_r.nlpCnt + 3'h1;
               if (st_r.nlpCnt == 3'(`PLDC_NLP_NEEDED - 1)) begin
                  st_nxt.link = pldc_pkg::PLDC_UP;
               end
            end
         end
         pldc_pkg::PLDC_UP: begin
            st_nxt.lossCnt = '0;
            if (line.speed100 && !line.sigDet) begin
               if (!fastLossEn) begin
                  st_nxt.link = pldc_pkg::PLDC_NOLINK;
               end else if (st_r.lossCnt ==
                            `PLDC_CNT_W'(FAST_LOSS_CYC - 1)) begin
                  st_nxt.link = pldc_pkg::PLDC_NOLINK;
               end else begin
                  st_nxt.lossCnt = st_r.lossCnt + `PLDC_CNT_W'(1);
               end
            end
         end
         default: begin
            st_nxt.link = pldc_pkg::PLDC_NOLINK;
         end
      endcase
      // blink timer runs only during activity
      if (!activity || st_r.blinkCnt >= blinkTop) begin
         st_nxt.blinkCnt = '0;
         st_nxt.blinkPh = activity ? ~st_r.blinkPh : 1'b0;
      end else begin
         st_nxt.blinkCnt = st_r.blinkCnt + `PLDC_CNT_W'(1);
      end
      // led drive with direct override and polarity
      for (int i = 0; i < 3; i++) begin
         st_nxt.led[i] = (ledCtrl.directEn[i] ? ledCtrl.directVal[i]
            : (i == 2 ? modeFunc2 : (i == 1 ? modeFunc1 : modeFunc0)))
            ^ st_r.pol[i];
      end
      // carrier sense and collision
      if (st_r.duplex) begin
         st_nxt.crs = line.rxAct;
         st_nxt.col = 1'b0;
      end else begin
         st_nxt.crs = line.rxAct | line.txAct;
         st_nxt.col = line.col;
      end
      // loopback path
      if (loopbackBit) begin
         st_nxt.rxd = txData;
         st_nxt.rxdv = txEn;
         st_nxt.txd = '0;
         st_nxt.txen = 1'b0;
      end else begin
         st_nxt.rxd = rxLineData;
         st_nxt.rxdv = rxLineDv;
         st_nxt.txd = txData;
         st_nxt.txen = txEn;
      end
   end

   // mode functions: link on, blink in modes 0 and 2
   always_comb begin
      modeFunc0 = (st_r.link == pldc_pkg::PLDC_UP);
      if (st_r.mode != 2'b01 && st_r.mode[0] != 1'b1 && activity) begin
         modeFunc0 = modeFunc0 & ~st_r.blinkPh;
      end
      modeFunc1 = line.speed100;
      if (st_r.mode[0]) begin
         modeFunc2 = activity;
      end else if (!st_r.mode[1]) begin
         modeFunc2 = st_r.col;
      end else begin
         modeFunc2 = st_r.duplex;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs
   assign linkIndicator = st_r.led[0];
   assign speedIndicator = st_r.led[1];
   assign activityIndicator = st_r.led[2];
   assign modeSel = st_r.mode;
   assign duplexFull = st_r.duplex;
   assign linkUp = (st_r.link == pldc_pkg::PLDC_UP);
   assign crs = st_r.crs;
   assign colOut = st_r.col;
   assign rxData = st_r.rxd;
   assign rxDv = st_r.rxdv;
   assign mediaTxData = st_r.txd;
   assign mediaTxEn = st_r.txen;
   assign loopbackSts = loopbackBit;
   // shared pin: power-down input or active low irq
   assign powerDown = powerDownBit | (!irqOutEn & !pdPinS);
   assign pdPinOe = irqOutEn & irqPending;
   assign pdPinOut = 1'b0;
endmodule : pldc_status_ctrl

/* File: shared/pldc_params.svh */
// timing constants, field positions and counter width of the status/control block
// How it works
// - led mode comes from a two-bit field, bits 6:5 of control reg 19h.
// - upper mode bit loads only by register write, never from a strap.
// - mode 1: link led shows good link, activity led shows tx/rx activity.
// - mode 2: activity led shows collision; the code shows collision in mode 0 and full duplex in mode 2.
// - mode 3: activity led shows full duplex at either speed; the code shows tx/rx activity in mode 3.
// - modes 2,3: link led on for link, blinks on activity at programmed rate; the code blinks in modes 0 and 2.
// - rx-only bit 8 of reg 18h picks receive alone as activity.
// - 10 Mb/s link after seven normal link pulses or one good packet.
// - fast loss enabled: link led drops about 1.3 us after signal loss.
// - speed led high at 100 Mb/s, low at 10 Mb/s, every mode.
// - 10 Mb/s half duplex collision led follows the mii collision signal.
// - each led polarity from strap: low strap active high, high active low.
// - software may drive leds directly; reads do not return pin states.
// - half duplex carrier sense covers transmit and receive.
// - full duplex: no collision, carrier sense for receive only.
// - duplex bit 8 of basic control; no negotiation in fiber mode.
// - fiber strap: duplex loads from strap0, other negotiation straps ignored.
// - parallel detected link settles on half duplex.
// - loopback bit 14 routes mii transmit to receive; status bit 3 reports it.
// - loopback sends nothing to the media; software disables negotiation first.
// - shared pin is power-down input until irq output enable is set.
// - pin low powers down like control bit 11; management still answers.
`ifndef PLDC_PARAMS_SVH
`define PLDC_PARAMS_SVH
`define PLDC_CLK_MHZ 100
`define PLDC_FAST_LOSS_NS 1300
`define PLDC_FAST_LOSS_CYC ((`PLDC_FAST_LOSS_NS * `PLDC_CLK_MHZ) / 1000)
`define PLDC_NLP_NEEDED 7
`define PLDC_BLINK_BASE 2500000
`define PLDC_MODE_LO 5
`define PLDC_MODE_HI 6
`define PLDC_CNT_W 27
`endif

/* File: shared/pldc_pkg.sv */
// types shared by the status and control block
package pldc_pkg;
   typedef struct packed {
      logic txAct;    // transmit activity
      logic rxAct;    // receive activity
      logic col;      // raw collision
      logic speed100; // operating at 100 Mb/s
      logic sigDet;   // 100 Mb signal detect
      logic nlp;      // one 10 Mb normal link pulse, pulse
      logic goodPkt;  // valid 10 Mb packet received, pulse
      logic parDet;   // link came from parallel detection
   } pldc_line_type;
   typedef struct packed {
      logic [1:0] blinkRate; // blink period select
      logic rxOnly;          // activity counts receive alone
      logic [2:0] directEn;  // per led direct control enable
      logic [2:0] directVal; // per led software value
   } pldc_led_ctrl_type;
   typedef enum logic [1:0] {
      PLDC_NOLINK,
      PLDC_PULSES,
      PLDC_UP
   } pldc_link_type;
endpackage : pldc_pkg

/* File: hdl/pldc_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pldc_sync #(
   parameter int W = 1 // width
) (
   input wire logic sys_clk, // clock
   input wire logic sys_rst, // sync reset
   input wire logic [W-1:0] din, // async in
   output logic [W-1:0] dout // synced out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pldc_sync_type;
   pldc_sync_type st_r, st_nxt;
   // shift chain
   always_comb begin
      st_nxt.s1 = din;
      st_nxt.s2 = st_r.s1;
   end
   always_ff @(posedge sys_clk) begin
      // reset preloads the pin level so straps are ready at release
      if (sys_rst) begin
         st_r.s1 <= din;
         st_r.s2 <= din;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign dout = st_r.s2;
endmodule : pldc_sync

/* File: tb/pldc_assertions.sv */
// concurrent checks of the status and control block
`timescale 1ns/1ps
module pldc_assertions (
   input wire logic sys_clk, // clock
   input wire logic sys_rst, // reset
   input wire pldc_pkg::pldc_line_type line, // core status
   input wire pldc_pkg::pldc_led_ctrl_type ledCtrl, // led reg
   input wire logic duplexWr, // duplex value
   input wire logic duplexWe, // duplex strobe
   input wire logic loopbackBit, // loopback
   input wire logic [2:0] strapIn, // straps
   input wire logic fiberStrap, // fiber strap
   input wire logic [7:0] txData, // mii tx
   input wire logic txEn, // mii tx enable
   input wire logic speedIndicator, // speed led
   input wire logic activityIndicator, // act led
   input wire logic [1:0] modeSel, // mode
   input wire logic duplexFull, // duplex
   input wire logic crs, // carrier
   input wire logic colOut, // collision
   input wire logic [7:0] rxData, // mii rx
   input wire logic rxDv, // mii rx valid
   input wire logic mediaTxEn // media tx
);
   // one clock, quiet in reset
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // loopback returns data, media stays silent
   property p_loop;
      loopbackBit && txEn |=> rxDv && rxData == $past(txData);
   endproperty
   a_loop: assert property (p_loop) else $error("loop data lost");
   property p_silent;
      loopbackBit && $past(loopbackBit) |-> !mediaTxEn;
   endproperty
   a_silent: assert property (p_silent) else $error("media busy");
   // carrier sense and collision by duplex
   property p_crs;
      !$past(sys_rst) && !$past(loopbackBit) && $stable(duplexFull)
         |-> crs == ($past(line.rxAct) | ($past(line.txAct) & !duplexFull));
   endproperty
   a_crs: assert property (p_crs) else $error("bad crs");
   property p_col;
      duplexFull && $past(duplexFull) |-> !colOut;
   endproperty
   a_col: assert property (p_col) else $error("full dup col");
   // led levels after strap polarity
   property p_speed;
      !$past(sys_rst, 3) && !$past(ledCtrl.directEn[1])
         |-> speedIndicator == ($past(line.speed100) ^ strapIn[1]);
   endproperty
   a_speed: assert property (p_speed) else $error("bad speed led");
   property p_act;
      modeSel[0] && $past(modeSel[0]) && !$past(ledCtrl.directEn[2])
         && !$past(sys_rst, 3) |-> activityIndicator == (strapIn[2] ^
         ($past(line.rxAct) | ($past(line.txAct) & !$past(ledCtrl.rxOnly))));
   endproperty
   a_act: assert property (p_act) else $error("bad act led");
   // duplex bit writes and parallel detect
   property p_dupwr;
      duplexWe && !$past(sys_rst) |=> duplexFull == $past(duplexWr);
   endproperty
   a_dupwr: assert property (p_dupwr) else $error("dup write");
   property p_pardet;
      $past(line.parDet) && !$past(duplexWe) && !$past(sys_rst)
         && !$past(sys_rst, 2) && !$past(fiberStrap, 3)
         && !$past(fiberStrap, 4) |-> !duplexFull;
   endproperty
   a_pardet: assert property (p_pardet) else $error("pardet dup");
endmodule : pldc_assertions
bind pldc_status_ctrl pldc_assertions chk (.*);

/* File: tb/pldc_far_model.sv */
// strap resistors, lamps and the shared pin's pull-up
`timescale 1ns/1ps
module pldc_far_model (
   input wire logic [2:0] strapLvl, // resistor levels
   input wire logic [2:0] pins, // led pin levels
   input wire logic pdDriveLow, // external pull low
   input wire logic pdPinOut, // device pin level
   input wire logic pdPinOe, // device drive enable
   output logic [2:0] strapIn, // levels read as straps
   output logic [2:0] ledOn, // lamp lit
   output logic pdPinIn // resolved shared pin
);
   // straps and lamps share the pins
   assign strapIn = strapLvl;
   assign ledOn = pins ^ strapLvl;
   // weak pull-up unless pulled low
   assign pdPinIn = ~((pdPinOe & ~pdPinOut) | pdDriveLow);
endmodule : pldc_far_model

/* File: tb/pldc_status_ctrl_test.sv */
// self-checking bench of the status and control block
`timescale 1ns/1ps
module pldc_status_ctrl_test;
   logic sys_clk = 0;
   logic sys_rst = 1;
   pldc_pkg::pldc_line_type line = '0;
   pldc_pkg::pldc_led_ctrl_type ledCtrl = '0;
   logic [1:0] modeSelWr = 0, modeSel;
   logic modeSelWe = 0, fastLossEn = 0, duplexWr = 0, duplexWe = 0;
   logic loopbackBit = 0, powerDownBit = 0, irqOutEn = 0, irqPending = 0;
   logic fiberStrap = 0, pdDriveLow = 0, txEn = 0, rxLineDv = 0;
   logic [2:0] strapLvl = 0, strapIn, ledOn;
   logic [7:0] txData = 0, rxLineData = 0, rxData, mediaTxData;
   logic linkIndicator, speedIndicator, activityIndicator, duplexFull;
   logic linkUp, crs, colOut, rxDv, mediaTxEn, loopbackSts, powerDown;
   logic pdPinOut, pdPinOe, pdPinIn;
   int errTotal = 0, numChecks = 0, cyc = 0;
   pldc_status_ctrl #(.FAST_LOSS_CYC(20), .BLINK_BASE(4)) dut (.*);
   pldc_far_model far (.pins({activityIndicator, speedIndicator,
      linkIndicator}), .*);
   // clock and hang guard
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errTotal++;
         $display("mismatch at %0t: timeout", $time);
         final_report();
      end
   end
   // compare, wait, reset, verdict
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      numChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic do_reset(input logic [2:0] s, input logic f);
      sys_rst = 1;
      strapLvl = s;
      fiberStrap = f;
      tick(10);
      sys_rst = 0;
      tick(2);
   endtask : do_reset
   task automatic final_report();
      if (errTotal == 0 && numChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report
   // lamp state of the activity led
   function automatic logic exp_act(input logic [1:0] m, input logic d);
      if (m[0]) begin
         return line.rxAct | (line.txAct & ~ledCtrl.rxOnly);
      end else if (m[1]) begin
         return d;
      end
      return line.col & ~d;
   endfunction : exp_act
   // main sequence
   initial begin
      logic [2:0] st [3] = '{3'h2, 3'h1, 3'h6};
      void'($urandom(32'hae8b_870c));
      for (int i = 0; i < 3; i++) begin
         do_reset(st[i], i > 0);
         check(modeSel, {1'b0, st[i][0]});
         check(duplexFull, i > 0 ? st[i][0] : st[i][1]);
      end
      for (int k = 0; k < 7; k++) begin
         check(linkUp, 0);
         line.nlp = 1;
         tick(1);
         line.nlp = 0;
         tick(1);
      end
      tick(2);
      check(linkUp, 1);
      check(ledOn[0], 1);
      do_reset(3'h6, 1);
      line.goodPkt = 1;
      tick(1);
      line.goodPkt = 0;
      tick(2);
      check(linkUp, 1);
      line.speed100 = 1;
      line.sigDet = 1;
      fastLossEn = 1;
      tick(4);
      line.sigDet = 0;
      tick(25);
      check(ledOn[0], 0);
      fiberStrap = 0;
      tick(3);
      line.parDet = 1;
      tick(2);
      check(duplexFull, 0);
      for (int m = 0; m < 4; m++) begin
         modeSelWr = m[1:0];
         modeSelWe = 1;
         tick(1);
         modeSelWe = 0;
         check(modeSel, m[1:0]);
         repeat (40) begin
            line = $urandom;
            line.parDet = 0;
            ledCtrl = $urandom;
            ledCtrl.directEn = 0;
            duplexWr = $urandom;
            duplexWe = $urandom;
            loopbackBit = $urandom;
            txEn = $urandom;
            txData = $urandom;
            rxLineData = $urandom;
            rxLineDv = $urandom;
            tick(3);
            check(ledOn[2], exp_act(m[1:0], duplexFull));
            check(ledOn[1], line.speed100);
         end
      end
      duplexWe = 0;
      repeat (4) begin
         ledCtrl.directEn = 3'h7;
         ledCtrl.directVal = $urandom;
         tick(2);
         check(ledOn, ledCtrl.directVal);
      end
      line = '0;
      ledCtrl = '0;
      pdDriveLow = 1;
      tick(4);
      check(powerDown, 1);
      pdDriveLow = 0;
      irqOutEn = 1;
      irqPending = 1;
      tick(4);
      check(pdPinIn, 0);
      check(powerDown, 0);
      powerDownBit = 1;
      tick(1);
      check(powerDown, 1);
      final_report();
   end
endmodule : pldc_status_ctrl_test
